// file: hw/atc_top.sv
// converter timing, repeat and result register block
`timescale 1ns/100ps
`include "atc_regs.svh"
// How it works
// - precharge lasts charge_setup_time clocks, zero skips it
// - sampling lasts sampling_window clocks of chosen clock
// - both fields zero skips the sampling phase
// - setup nonzero, window zero gives 8192 clocks
// - extra_sample_load picks 0 to 31 pF
// - threshold checked when tally reaches repeat goal
// - tally counts conversion starts, software rw, resets zero
// - goal and tally used only in filter, average modes
// - accumulate modes: output is sum shifted right
// - low pass mode loads filter result
// - smoothed output is signed 16-bit, read only
// - conversion outcome 16-bit, rw, resets zero
// - earlier outcome 16-bit read only, resets zero
// - timing registers split into high and low bytes
// - conversion outcome split into high and low bytes
// - codes 0,1,2 route port a inputs 0,1,2
// - conversion start captures earlier outcome by source
module atc_top
  import atc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [11:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  input wire logic trigger,
  input wire logic dedicated_rc_oscillator,
  input wire logic core_done,
  input wire logic [11:0] core_data,
  input wire logic signed [17:0] running_sum,
  input wire logic signed [15:0] low_pass_result,
  output atc_core_req_type core_req,
  output logic threshold_check,
  output logic irq
);

  atc_bus_type bus;
  atc_ctrl_type ctrl_q;
  atc_phase_type phase_q;
  logic [12:0] pre_q;
  logic [12:0] acq_q;
  logic [4:0] cap_q;
  logic [7:0] goal_q;
  logic [7:0] tally_q;
  logic [6:0] chan_q;
  logic signed [15:0] flt_q;
  logic [15:0] res_q;
  logic [15:0] prev_q;
  logic [13:0] cnt_q;
  logic [1:0] irq_st_q;
  logic [1:0] irq_en_q;
  logic go_q;
  logic [2:0] rc_sync_q;
  logic [2:0] done_sync_q;
  logic tick;
  logic done_evt;
  logic start;
  logic repeat_mode;
  logic cnt_last;
  logic at_goal;
  logic [1:0] irq_set;
  logic [13:0] acq_cnt;
  logic [11:0] data_sync1_q;
  logic [11:0] data_sync2_q;
  logic [1:0] irq_clr;
  logic [1:0] irq_st_d;
  logic conv_end;
  logic thr_hit;
  logic converting;
  logic busy;

  assign bus = '{addr: bus_addr, wdata: bus_wdata, wr: bus_wr, rd: bus_rd};

  function automatic logic wr_at(input atc_bus_type b, input logic [11:0] a);
    wr_at = b.wr && (b.addr == a);
  endfunction

  function automatic logic [13:0] count_down(input logic [13:0] c);
    count_down = 14'(c - 14'h0001);
  endfunction

  function automatic logic [7:0] hi_byte(input logic [12:0] v);
    hi_byte = {3'h0, v[`ATC_HI_BITS]};
  endfunction

  // rc clock and core done, two flops then edge
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rc_sync_q <= 3'h0;
      done_sync_q <= 3'h0;
    end else begin
      rc_sync_q <= {rc_sync_q[1:0], dedicated_rc_oscillator};
      done_sync_q <= {done_sync_q[1:0], core_done};
    end
  end

  // conversion value, two flops before use
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      data_sync1_q <= 12'h000;
      data_sync2_q <= 12'h000;
    end else begin
      data_sync1_q <= core_data;
      data_sync2_q <= data_sync1_q;
    end
  end

  // one tick per period of the selected timing clock
  assign tick = ctrl_q.timing_clock_pick ? (rc_sync_q[1] && !rc_sync_q[2]) : 1'b1;
  assign done_evt = done_sync_q[1] && !done_sync_q[2];
  assign converting = (phase_q == ATC_CONVERT);
  assign busy = (phase_q != ATC_IDLE);
  assign conv_end = converting && done_evt;
  assign thr_hit = start && repeat_mode && at_goal;
  assign start = (phase_q == ATC_IDLE) && (go_q || trigger);
  assign cnt_last = tick && (cnt_q == 14'h0001);
  assign repeat_mode = (ctrl_q.mode == ATC_MODE_LOW_PASS)
                    || (ctrl_q.mode == ATC_MODE_BURST_AVG)
                    || (ctrl_q.mode == ATC_MODE_AVERAGE);
  assign at_goal = (8'(tally_q + 8'h01) == goal_q);
  assign acq_cnt = (acq_q == `ATC_RST_TIME) ? `ATC_ACQ_DEFAULT_CNT : {1'b0, acq_q};

  // control registers written by software
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_q <= '0;
      chan_q <= 7'h00;
      pre_q <= `ATC_RST_TIME;
      acq_q <= `ATC_RST_TIME;
      cap_q <= 5'h00;
      goal_q <= `ATC_RST_BYTE;
    end else begin
      if (wr_at(bus, `ATC_OFS_CTRL)) begin
        ctrl_q <= bus.wdata;
      end
      if (wr_at(bus, `ATC_OFS_CHAN)) begin
        chan_q <= bus.wdata[6:0];
      end
      if (wr_at(bus, `ATC_OFS_PRE_L)) begin
        pre_q[7:0] <= bus.wdata;
      end
      if (wr_at(bus, `ATC_OFS_PRE_H)) begin
        pre_q[`ATC_HI_BITS] <= bus.wdata[4:0];
      end
      if (wr_at(bus, `ATC_OFS_ACQ_L)) begin
        acq_q[7:0] <= bus.wdata;
      end
      if (wr_at(bus, `ATC_OFS_ACQ_H)) begin
        acq_q[`ATC_HI_BITS] <= bus.wdata[4:0];
      end
      if (wr_at(bus, `ATC_OFS_CAP)) begin
        cap_q <= bus.wdata[4:0];
      end
      if (wr_at(bus, `ATC_OFS_GOAL)) begin
        goal_q <= bus.wdata;
      end
    end
  end

  // software start request, held until taken
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      go_q <= 1'b0;
    end else if (start) begin
      go_q <= 1'b0;
    end else if (wr_at(bus, `ATC_OFS_GO)) begin
      go_q <= bus.wdata[0];
    end
  end

  // conversion sequence and phase counter
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      phase_q <= ATC_IDLE;
      cnt_q <= 14'h0000;
    end else begin
      unique case (phase_q)
        ATC_IDLE: begin
          if (start && pre_q != `ATC_RST_TIME) begin
            phase_q <= ATC_PRECHARGE;
            cnt_q <= {1'b0, pre_q};
          end else if (start && acq_q != `ATC_RST_TIME) begin
            phase_q <= ATC_SAMPLE;
            cnt_q <= acq_cnt;
          end else if (start) begin
            phase_q <= ATC_CONVERT;
          end
        end
        ATC_PRECHARGE: begin
          if (cnt_last) begin
            phase_q <= ATC_SAMPLE;
            cnt_q <= acq_cnt;
          end else if (tick) begin
            cnt_q <= count_down(cnt_q);
          end
        end
        ATC_SAMPLE: begin
          if (cnt_last) begin
            phase_q <= ATC_CONVERT;
          end else if (tick) begin
            cnt_q <= count_down(cnt_q);
          end
        end
        ATC_CONVERT: begin
          if (done_evt) begin
            phase_q <= ATC_IDLE;
          end
        end
      endcase
    end
  end

  // request lines towards the analog core
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      core_req <= '0;
    end else begin
      core_req.precharge <= (phase_q == ATC_PRECHARGE);
      core_req.sample <= (phase_q == ATC_SAMPLE);
      core_req.convert <= converting;
      core_req.extra_sample_load <= cap_q;
      core_req.port_a_analog_sel[0] <= (chan_q == `ATC_CHAN_A0);
      core_req.port_a_analog_sel[1] <= (chan_q == `ATC_CHAN_A1);
      core_req.port_a_analog_sel[2] <= (chan_q == `ATC_CHAN_A2);
    end
  end

  // result and earlier result
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      res_q <= `ATC_RST_WORD;
      prev_q <= `ATC_RST_WORD;
    end else begin
      if (start) begin
        prev_q <= ctrl_q.earlier_source_pick ? flt_q : res_q;
      end
      if (conv_end) begin
        res_q <= {4'h0, data_sync2_q};
      end else begin
        if (wr_at(bus, `ATC_OFS_RES_L)) begin
          res_q[7:0] <= bus.wdata;
        end
        if (wr_at(bus, `ATC_OFS_RES_H)) begin
          res_q[15:8] <= bus.wdata;
        end
      end
    end
  end

  // smoothed output from the computation inputs
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      flt_q <= '0;
    end else begin
      unique case (ctrl_q.mode)
        ATC_MODE_ACCUM, ATC_MODE_AVERAGE, ATC_MODE_BURST_AVG: begin
          flt_q <= 16'(running_sum >>> ctrl_q.shift_amount);
        end
        ATC_MODE_LOW_PASS: begin
          flt_q <= low_pass_result;
        end
        default: begin
          flt_q <= flt_q;
        end
      endcase
    end
  end

  // repeat tally and threshold check pulse
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tally_q <= `ATC_RST_BYTE;
      threshold_check <= 1'b0;
    end else begin
      threshold_check <= thr_hit;
      if (start && repeat_mode) begin
        tally_q <= at_goal ? 8'h00 : 8'(tally_q + 8'h01);
      end else if (wr_at(bus, `ATC_OFS_TALLY)) begin
        tally_q <= bus.wdata;
      end
    end
  end

  // sticky interrupt status, set wins over clear
  assign irq_set[`ATC_IRQ_DONE] = conv_end;
  assign irq_set[`ATC_IRQ_THRESH] = thr_hit;
  assign irq_clr = wr_at(bus, `ATC_OFS_IRQ_CLR) ? bus.wdata[1:0] : 2'h0;

  for (genvar g = 0; g < 2; g++) begin : g_irq_bit
    assign irq_st_d[g] = irq_set[g] || (irq_st_q[g] && !irq_clr[g]);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_st_q <= 2'h0;
      irq_en_q <= 2'h0;
      irq <= 1'b0;
    end else begin
      irq_st_q <= irq_st_d;
      if (wr_at(bus, `ATC_OFS_IRQ_EN)) begin
        irq_en_q <= bus.wdata[1:0];
      end
      irq <= |((irq_st_q | irq_set) & irq_en_q);
    end
  end

  // read data, one cycle after the read strobe
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bus_rdata <= 8'h00;
    end else if (bus.rd) begin
      unique case (bus.addr)
        `ATC_OFS_FLT_L: bus_rdata <= flt_q[7:0];
        `ATC_OFS_FLT_H: bus_rdata <= flt_q[15:8];
        `ATC_OFS_TALLY: bus_rdata <= tally_q;
        `ATC_OFS_GOAL: bus_rdata <= goal_q;
        `ATC_OFS_PREV_L: bus_rdata <= prev_q[7:0];
        `ATC_OFS_PREV_H: bus_rdata <= prev_q[15:8];
        `ATC_OFS_RES_L: bus_rdata <= res_q[7:0];
        `ATC_OFS_RES_H: bus_rdata <= res_q[15:8];
        `ATC_OFS_ACQ_L: bus_rdata <= acq_q[7:0];
        `ATC_OFS_ACQ_H: bus_rdata <= hi_byte(acq_q);
        `ATC_OFS_CAP: bus_rdata <= {3'h0, cap_q};
        `ATC_OFS_PRE_L: bus_rdata <= pre_q[7:0];
        `ATC_OFS_PRE_H: bus_rdata <= hi_byte(pre_q);
        `ATC_OFS_CTRL: bus_rdata <= ctrl_q;
        `ATC_OFS_CHAN: bus_rdata <= {1'b0, chan_q};
        `ATC_OFS_GO: bus_rdata <= {7'h00, go_q};
        `ATC_OFS_STAT: bus_rdata <= {6'h00, converting, busy};
        `ATC_OFS_IRQ_ST: bus_rdata <= {6'h00, irq_st_q};
        `ATC_OFS_IRQ_EN: bus_rdata <= {6'h00, irq_en_q};
        default: bus_rdata <= 8'h00;
      endcase
    end else begin
      bus_rdata <= 8'h00;
    end
  end

endmodule

// file: hw/atc_regs.svh
// register offsets, fields, reset values and timing counts
`ifndef ATC_REGS_SVH
`define ATC_REGS_SVH
`define ATC_OFS_FLT_L 12'h3e1
`define ATC_OFS_FLT_H 12'h3e2
`define ATC_OFS_TALLY 12'h3e6
`define ATC_OFS_GOAL 12'h3e7
`define ATC_OFS_PREV_L 12'h3e8
`define ATC_OFS_PREV_H 12'h3e9
`define ATC_OFS_RES_L 12'h3ea
`define ATC_OFS_RES_H 12'h3eb
`define ATC_OFS_ACQ_L 12'h3ee
`define ATC_OFS_ACQ_H 12'h3ef
`define ATC_OFS_CAP 12'h3f0
`define ATC_OFS_PRE_L 12'h3f1
`define ATC_OFS_PRE_H 12'h3f2
`define ATC_OFS_CTRL 12'h3c0
`define ATC_OFS_CHAN 12'h3c1
`define ATC_OFS_GO 12'h3c2
`define ATC_OFS_STAT 12'h3c3
`define ATC_OFS_IRQ_ST 12'h3c4
`define ATC_OFS_IRQ_CLR 12'h3c5
`define ATC_OFS_IRQ_EN 12'h3c6
`define ATC_CTRL_MODE 2:0
`define ATC_CTRL_SHIFT 5:3
`define ATC_CTRL_CLK_PICK 6
`define ATC_CTRL_SRC_PICK 7
`define ATC_HI_BITS 12:8
`define ATC_CHAN_A0 7'h00
`define ATC_CHAN_A1 7'h01
`define ATC_CHAN_A2 7'h02
`define ATC_RST_BYTE 8'h00
`define ATC_RST_WORD 16'h0000
`define ATC_RST_TIME 13'h0000
`define ATC_ACQ_DEFAULT_CNT 14'h2000
`define ATC_IRQ_DONE 0
`define ATC_IRQ_THRESH 1
`endif

// file: hw/atc_pkg.sv
// types shared by the timing and result register block
package atc_pkg;
  typedef enum logic [2:0] {
    ATC_MODE_BASIC,
    ATC_MODE_ACCUM,
    ATC_MODE_AVERAGE,
    ATC_MODE_BURST_AVG,
    ATC_MODE_LOW_PASS
  } atc_mode_type;
  typedef enum {
    ATC_IDLE,
    ATC_PRECHARGE,
    ATC_SAMPLE,
    ATC_CONVERT
  } atc_phase_type;
  typedef struct packed {
    logic earlier_source_pick;
    logic timing_clock_pick;
    logic [2:0] shift_amount;
    logic [2:0] mode;
  } atc_ctrl_type;
  typedef struct packed {
    logic precharge;
    logic sample;
    logic convert;
    logic [2:0] port_a_analog_sel;
    logic [4:0] extra_sample_load;
  } atc_core_req_type;
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } atc_bus_type;
endpackage

// file: testbench/atc_top_properties.sv
// port assertions for the timing and result block
`timescale 1ns/100ps
module atc_top_properties
  import atc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [11:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_rdata,
  input wire logic trigger,
  input wire logic dedicated_rc_oscillator,
  input wire logic core_done,
  input wire logic [11:0] core_data,
  input wire logic signed [17:0] running_sum,
  input wire logic signed [15:0] low_pass_result,
  input wire atc_core_req_type core_req,
  input wire logic threshold_check,
  input wire logic irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic pc, sm, cv, act;
  assign pc = core_req.precharge;
  assign sm = core_req.sample;
  assign cv = core_req.convert;
  assign act = pc || sm || cv;
  rdata_quiet_a: assert property (!$past(bus_rd) |-> bus_rdata == 8'h00)
    else $error("read data outside its cycle");
  phase_single_a: assert property ($onehot0({pc, sm, cv}))
    else $error("two phases at once");
  chan_onehot_a: assert property ($onehot0(core_req.port_a_analog_sel))
    else $error("channel select not one-hot");
  thresh_pulse_a: assert property (threshold_check |=> !threshold_check)
    else $error("threshold pulse too long");
  pre_then_samp_a: assert property ($fell(pc) |-> sm)
    else $error("sampling skipped after precharge");
  samp_then_conv_a: assert property ($fell(sm) |-> cv)
    else $error("convert missing after sampling");
  conv_end_a: assert property ($fell(cv) |-> $past(core_done, 3) || $past(core_done, 4))
    else $error("convert ended without core done");
  sel_steady_a: assert property (act && $past(act) |-> $stable(core_req.port_a_analog_sel))
    else $error("channel changed mid conversion");
  cover property ($fell(cv));
  cover property (threshold_check);
  cover property ($rose(irq));
endmodule
bind atc_top atc_top_properties u_props (.clk_sys(clk_sys), .rst(rst), .bus_addr(bus_addr),
  .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .trigger(trigger),
  .dedicated_rc_oscillator(dedicated_rc_oscillator), .core_done(core_done), .core_data(core_data),
  .running_sum(running_sum), .low_pass_result(low_pass_result), .core_req(core_req),
  .threshold_check(threshold_check), .irq(irq));

// file: testbench/atc_core_model.sv
// analog core model answering convert requests
`timescale 1ns/100ps
module atc_core_model
  import atc_pkg::*;
(
  input wire logic clk_sys,
  input wire atc_core_req_type core_req,
  output logic core_done,
  output logic [11:0] core_data
);
  int n = 0;
  initial core_done = 1'b0;
  initial core_data = 12'h543;
  // done rises some cycles into convert, data changes outside it
  always @(posedge clk_sys) begin
    n <= core_req.convert ? n + 1 : 0;
    core_done <= core_req.convert && n >= 4;
    core_data <= core_req.convert ? 12'habc : ~core_data;
  end
endmodule

// file: testbench/atc_top_tb_top.sv
// self-checking bench for the timing and result block
`timescale 1ns/100ps
`include "atc_regs.svh"
module atc_top_tb_top
  import atc_pkg::*;
;
  logic clk_sys = 1'b0, rst = 1'b1, bus_wr = 1'b0, bus_rd = 1'b0, trigger = 1'b0, rc = 1'b0;
  logic [11:0] bus_addr = '0;
  logic [7:0] bus_wdata = '0, bus_rdata;
  logic signed [17:0] running_sum = '0;
  logic signed [15:0] low_pass_result = '0;
  atc_core_req_type core_req;
  logic threshold_check, irq, core_done;
  logic [11:0] core_data;
  int mismatches = 0, total_checks = 0, cp, cs, tc = 0;
  atc_top DUT (.clk_sys(clk_sys), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata(bus_rdata), .trigger(trigger), .dedicated_rc_oscillator(rc),
    .core_done(core_done), .core_data(core_data), .running_sum(running_sum),
    .low_pass_result(low_pass_result), .core_req(core_req), .threshold_check(threshold_check), .irq(irq));
  atc_core_model core (.clk_sys(clk_sys), .core_req(core_req), .core_done(core_done), .core_data(core_data));
  initial forever #20 clk_sys = ~clk_sys;
  initial forever #143 rc = ~rc;
  task print_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task chk(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clk_sys);
    bus_wr <= 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk_sys);
    bus_rd <= 1'b0;
    #1;
    chk(bus_rdata, e);
  endtask
  // start by trigger or go bit, count phase cycles until idle
  task cv(input bit t, input int ep, input int es);
    int i;
    cp = 0;
    cs = 0;
    if (t) begin
      @(posedge clk_sys);
      trigger <= 1'b1;
      @(posedge clk_sys);
      trigger <= 1'b0;
    end else begin
      wr(`ATC_OFS_GO, 8'h01);
    end
    for (i = 0; i < 9000 && (i < 4 || core_req.precharge || core_req.sample || core_req.convert); i++) begin
      @(negedge clk_sys);
      cp += core_req.precharge;
      cs += core_req.sample;
      tc += threshold_check;
    end
    if (i == 9000) begin
      mismatches++;
      $display("BAD %0t conversion did not finish", $time);
      print_verdict();
    end
    if (ep >= 0) begin
      chk(cp, ep);
      chk(cs, es);
    end
  endtask
  task tm(input logic [12:0] p, input logic [12:0] a, input int ep, input int es);
    wr(`ATC_OFS_PRE_L, p[7:0]);
    wr(`ATC_OFS_PRE_H, {3'h0, p[12:8]});
    wr(`ATC_OFS_ACQ_L, a[7:0]);
    wr(`ATC_OFS_ACQ_H, {3'h0, a[12:8]});
    cv(1'b0, ep, es);
  endtask
  task t_reset();
    rd(`ATC_OFS_TALLY, 8'h00);
    rd(`ATC_OFS_PREV_H, 8'h00);
    rd(`ATC_OFS_RES_L, 8'h00);
    rd(`ATC_OFS_ACQ_H, 8'h00);
    rd(12'h3f8, 8'h00);
    $display("reset test done");
  endtask
  task t_bytes();
    wr(`ATC_OFS_ACQ_H, 8'hff);
    rd(`ATC_OFS_ACQ_H, 8'h1f);
    wr(`ATC_OFS_PRE_L, 8'ha5);
    rd(`ATC_OFS_PRE_L, 8'ha5);
    wr(`ATC_OFS_RES_H, 8'h5a);
    rd(`ATC_OFS_RES_H, 8'h5a);
    wr(`ATC_OFS_PREV_L, 8'h77);
    rd(`ATC_OFS_PREV_L, 8'h00);
    wr(`ATC_OFS_FLT_H, 8'h77);
    rd(`ATC_OFS_FLT_H, 8'h00);
    $display("byte test done");
  endtask
  task t_timing();
    tm(13'h0002, 13'h0003, 2, 3);
    tm(13'h0000, 13'h0002, 0, 2);
    tm(13'h0000, 13'h0000, 0, 0);
    rd(`ATC_OFS_RES_L, 8'hbc);
    rd(`ATC_OFS_RES_H, 8'h0a);
    tm(13'h0001, 13'h0000, 1, 8192);
    rd(`ATC_OFS_PREV_L, 8'hbc);
    wr(`ATC_OFS_CTRL, 8'h40);
    tm(13'h0002, 13'h0001, -1, -1);
    chk(cp >= 6 && cp <= 17, 16'h0001);
    $display("timing test done");
  endtask
  task t_chan();
    int k;
    for (k = 0; k < 4; k++) begin
      wr(`ATC_OFS_CHAN, 8'(k));
      wr(`ATC_OFS_CAP, 8'(k * 10 + (k > 0)));
      repeat (2) @(posedge clk_sys);
      #1;
      chk(core_req.port_a_analog_sel, (k < 3) ? 16'(1 << k) : 16'h0);
      chk(core_req.extra_sample_load, 16'(k * 10 + (k > 0)));
    end
    $display("select test done");
  endtask
  task t_repeat();
    wr(`ATC_OFS_CTRL, 8'h02);
    wr(`ATC_OFS_GOAL, 8'h03);
    rd(`ATC_OFS_GOAL, 8'h03);
    wr(`ATC_OFS_TALLY, 8'h02);
    wr(`ATC_OFS_IRQ_CLR, 8'h03);
    tc = 0;
    cv(1'b1, 2, 1);
    chk(tc, 16'h0001);
    rd(`ATC_OFS_TALLY, 8'h00);
    chk(irq, 16'h0000);
    rd(`ATC_OFS_IRQ_ST, 8'h03);
    wr(`ATC_OFS_IRQ_EN, 8'h02);
    cv(1'b1, 2, 1);
    rd(`ATC_OFS_TALLY, 8'h01);
    chk(irq, 16'h0001);
    wr(`ATC_OFS_IRQ_CLR, 8'h03);
    @(posedge clk_sys);
    #1;
    chk(irq, 16'h0000);
    wr(`ATC_OFS_CTRL, 8'h00);
    tc = 0;
    repeat (3) cv(1'b0, 2, 1);
    chk(tc, 16'h0000);
    rd(`ATC_OFS_TALLY, 8'h01);
    $display("repeat test done");
  endtask
  task t_smooth();
    @(posedge clk_sys);
    running_sum <= 18'h3fc00;
    low_pass_result <= 16'h1234;
    wr(`ATC_OFS_CTRL, 8'h11);
    rd(`ATC_OFS_FLT_L, 8'h00);
    rd(`ATC_OFS_FLT_H, 8'hff);
    wr(`ATC_OFS_CTRL, 8'h1b);
    rd(`ATC_OFS_FLT_L, 8'h80);
    wr(`ATC_OFS_CTRL, 8'h84);
    rd(`ATC_OFS_FLT_L, 8'h34);
    tm(13'h0000, 13'h0000, 0, 0);
    rd(`ATC_OFS_PREV_H, 8'h12);
    $display("smoothing test done");
  endtask
  initial begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_bytes();
    t_timing();
    t_chan();
    t_repeat();
    t_smooth();
    print_verdict();
  end
endmodule
